// File: core/hpsi_defines.svh
// constants for the hot-plug slot interface: positions, reset values and timing counts
`ifndef HPSI_DEFINES_SVH
`define HPSI_DEFINES_SVH

// clock and debounce timing
`define HPSI_CLK_KHZ          20000
`define HPSI_DEBOUNCE_MS      8
`define HPSI_DEBOUNCE_CYCLES  (`HPSI_DEBOUNCE_MS * `HPSI_CLK_KHZ)

// synchroniser vector layout
`define HPSI_PIN_W            6
`define HPSI_PIN_FAULT        5
`define HPSI_PIN_PRES_A       4
`define HPSI_PIN_PRES_B       3
`define HPSI_PIN_LATCH        2
`define HPSI_PIN_BUTTON       1
`define HPSI_PIN_FAST         0
`define HPSI_PIN_IDLE         6'h3e

// debounced switch vector layout
`define HPSI_SW_W             4
`define HPSI_SW_PRES_A        3
`define HPSI_SW_PRES_B        2
`define HPSI_SW_LATCH         1
`define HPSI_SW_BUTTON        0
`define HPSI_SW_IDLE          4'hf

// configured slot count that selects the direct mode
`define HPSI_SLOT_CNT_W       4
`define HPSI_DIRECT_SLOTS     4'h1

// output reset values
`define HPSI_RST_SLOT_RESET_N 1'h0
`define HPSI_RST_POWER_EN     1'h0
`define HPSI_RST_IND_N        1'h1

`endif

// File: core/hpsi_pkg.sv
// types for the hot-plug slot interface
package hpsi_pkg;

	// board power class as seen on the two presence pins
	typedef enum logic [1:0] {
		HPSI_NO_BOARD,
		HPSI_BOARD_25W,
		HPSI_BOARD_15W,
		HPSI_BOARD_7W5
	} hpsi_pwr_class_t;

	// presence pin pair to power class
	function automatic hpsi_pwr_class_t hpsi_decode_presence(input logic pres_a_n, input logic pres_b_n);
		hpsi_pwr_class_t cls;
		cls = HPSI_NO_BOARD;
		unique case ({pres_a_n, pres_b_n})
			2'h3: cls = HPSI_NO_BOARD;
			2'h1: cls = HPSI_BOARD_25W;
			2'h2: cls = HPSI_BOARD_15W;
			2'h0: cls = HPSI_BOARD_7W5;
		endcase
		return cls;
	endfunction

endpackage

// File: core/hpsi_debounce.sv
// shared stability filter for the slot switch inputs
`timescale 1ns/100ps
`default_nettype none
`include "hpsi_defines.svh"

module hpsi_debounce #(
	parameter int unsigned STABLE_CYCLES = `HPSI_DEBOUNCE_CYCLES
) (
	input  wire logic                  clock_i,
	input  wire logic                  rst_i,
	input  wire logic [`HPSI_SW_W-1:0] sample_i,   // already synchronised
	output logic      [`HPSI_SW_W-1:0] stable_o    // accepted switch state
);
	localparam int CW = $clog2(STABLE_CYCLES + 1);
	localparam logic [CW-1:0] LAST_CNT = CW'(STABLE_CYCLES - 1);

	logic [`HPSI_SW_W-1:0] last_r;   // most recent sample
	logic [CW-1:0]         cnt_r;    // cycles the sample has held
	logic                  moved;    // any switch changed this cycle
	logic                  settled;  // full interval elapsed

	assign moved   = (sample_i != last_r);
	assign settled = (cnt_r == LAST_CNT);

	// one timer for all switches: a change anywhere restarts it
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			last_r <= `HPSI_SW_IDLE;
			cnt_r  <= '0;
		end else if (moved) begin
			last_r <= sample_i;
			cnt_r  <= '0;
		end else if (!settled) begin
			cnt_r  <= cnt_r + CW'(1);
		end
	end

	// accept only after the whole quiet interval
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			stable_o <= `HPSI_SW_IDLE;
		end else if (settled && !moved) begin
			stable_o <= last_r;
		end
	end

	property p_accept_after_interval;
		@(posedge clock_i) disable iff (rst_i)
		(stable_o != $past(stable_o)) |-> ($past(cnt_r) == LAST_CNT && $past(last_r) == stable_o);
	endproperty
	a_accept_after_interval: assert property (p_accept_after_interval) else $error("switch accepted early");

	property p_restart_on_change;
		@(posedge clock_i) disable iff (rst_i)
		moved |=> (cnt_r == '0);
	endproperty
	a_restart_on_change: assert property (p_restart_on_change) else $error("timer not restarted");

	c_accept: cover property (@(posedge clock_i) disable iff (rst_i) stable_o != $past(stable_o));

endmodule // hpsi_debounce
`default_nettype wire

// File: core/hpsi_slot_if.sv
// slot-side hot-plug interface for a single directly driven slot
`timescale 1ns/100ps
`default_nettype none
`include "hpsi_defines.svh"

module hpsi_slot_if
	import hpsi_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = `HPSI_DEBOUNCE_CYCLES
) (
	input  wire logic                       clock_i,
	input  wire logic                       rst_i,
	// slot pins
	input  wire logic                       seg_power_fault_n_i,
	input  wire logic                       seg_presence_a_n_i,
	input  wire logic                       seg_presence_b_n_i,
	input  wire logic                       seg_latch_sensor_n_i,
	input  wire logic                       seg_attention_button_n_i,
	input  wire logic                       seg_card_fast_capable_i,
	output logic                            seg_slot_power_enable_o,
	output logic                            seg_slot_reset_n_o,
	output logic                            seg_power_indicator_n_o,
	output logic                            seg_attention_indicator_n_o,
	// controller side, same clock
	input  wire logic [`HPSI_SLOT_CNT_W-1:0] slot_count_i,
	input  wire logic                       fault_response_en_i,
	input  wire logic                       fault_clear_i,
	input  wire logic                       power_cmd_i,
	input  wire logic                       bus_connect_cmd_i,
	input  wire logic                       slot_run_cmd_i,
	input  wire logic                       power_indicator_on_i,
	input  wire logic                       attention_indicator_on_i,
	output logic                            direct_mode_o,
	output logic                            bus_connect_o,
	output logic                            fault_trip_o,
	output logic                            fault_seen_o,
	output hpsi_pwr_class_t                 card_power_class_o,
	output logic                            latch_closed_o,
	output logic                            attention_request_o,
	output logic                            card_fast_capable_o
);

	logic [`HPSI_PIN_W-1:0] pin_s1_r;      // first sync stage, read only by stage two
	logic [`HPSI_PIN_W-1:0] pin_s2_r;      // synchronised pins
	logic [`HPSI_SW_W-1:0]  sw_sample;     // synced switches for the filter
	logic [`HPSI_SW_W-1:0]  sw_stable;     // filtered switches
	logic                   button_prev_r; // last filtered button level
	logic                   fault_act;     // fault pin asserted
	logic                   direct_mode;   // single directly driven slot
	logic                   trip_nxt;
	logic                   seen_nxt;
	logic                   reset_n_nxt;
	logic                   power_en_nxt;
	logic                   connect_nxt;
	logic                   button_press;

	// two flip-flops on every pin before any logic looks at it
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_r <= `HPSI_PIN_IDLE;
			pin_s2_r <= `HPSI_PIN_IDLE;
		end else begin
			pin_s1_r <= {seg_power_fault_n_i, seg_presence_a_n_i, seg_presence_b_n_i,
				seg_latch_sensor_n_i, seg_attention_button_n_i, seg_card_fast_capable_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	// switch inputs go through the shared filter
	assign sw_sample = {pin_s2_r[`HPSI_PIN_PRES_A], pin_s2_r[`HPSI_PIN_PRES_B],
		pin_s2_r[`HPSI_PIN_LATCH], pin_s2_r[`HPSI_PIN_BUTTON]};

	hpsi_debounce #(
		.STABLE_CYCLES (DEBOUNCE_CYCLES)
	) u_debounce (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.sample_i (sw_sample),
		.stable_o (sw_stable)
	);

	// fault is not filtered: a slow reaction could damage the card
	assign fault_act    = ~pin_s2_r[`HPSI_PIN_FAULT];
	assign direct_mode  = (slot_count_i == `HPSI_DIRECT_SLOTS);
	// a fault in the clearing cycle keeps the flag: set wins
	assign trip_nxt     = (fault_trip_o & ~fault_clear_i) | (fault_act & fault_response_en_i);
	assign seen_nxt     = (fault_seen_o & ~fault_clear_i) | fault_act;
	// outside direct mode the slot stays held in reset, unpowered
	assign reset_n_nxt  = direct_mode & slot_run_cmd_i & ~trip_nxt;
	assign connect_nxt  = direct_mode & bus_connect_cmd_i & ~trip_nxt;
	assign power_en_nxt = direct_mode & power_cmd_i;
	assign button_press = button_prev_r & ~sw_stable[`HPSI_SW_BUTTON];

	// slot control outputs, all from flip-flops
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			seg_slot_reset_n_o          <= `HPSI_RST_SLOT_RESET_N;
			seg_slot_power_enable_o     <= `HPSI_RST_POWER_EN;
			seg_power_indicator_n_o     <= `HPSI_RST_IND_N;
			seg_attention_indicator_n_o <= `HPSI_RST_IND_N;
			bus_connect_o               <= 1'h0;
			direct_mode_o               <= 1'h0;
		end else begin
			seg_slot_reset_n_o          <= reset_n_nxt;
			seg_slot_power_enable_o     <= power_en_nxt;
			seg_power_indicator_n_o     <= ~(direct_mode & power_indicator_on_i);
			seg_attention_indicator_n_o <= ~(direct_mode & attention_indicator_on_i);
			bus_connect_o               <= connect_nxt;
			direct_mode_o               <= direct_mode;
		end
	end

	// fault flags: trip forces isolation, seen is status only
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fault_trip_o <= 1'h0;
			fault_seen_o <= 1'h0;
		end else begin
			fault_trip_o <= trip_nxt;
			fault_seen_o <= seen_nxt;
		end
	end

	// slot status decoded from filtered switches; speed capability taken from the synchronised pin
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			card_power_class_o  <= HPSI_NO_BOARD;
			latch_closed_o      <= 1'h0;
			attention_request_o <= 1'h0;
			button_prev_r       <= 1'h1;
			card_fast_capable_o <= 1'h0;
		end else begin
			card_power_class_o  <= hpsi_decode_presence(sw_stable[`HPSI_SW_PRES_A],
				sw_stable[`HPSI_SW_PRES_B]);
			latch_closed_o      <= ~sw_stable[`HPSI_SW_LATCH];
			attention_request_o <= button_press;
			button_prev_r       <= sw_stable[`HPSI_SW_BUTTON];
			card_fast_capable_o <= pin_s2_r[`HPSI_PIN_FAST];
		end
	end

	// checks
	property p_fault_isolate;
		@(posedge clock_i) disable iff (rst_i)
		(fault_act && fault_response_en_i) |=> (!seg_slot_reset_n_o && !bus_connect_o && fault_trip_o);
	endproperty
	a_fault_isolate: assert property (p_fault_isolate) else $error("fault did not isolate slot");

	property p_fault_gated;
		@(posedge clock_i) disable iff (rst_i)
		(fault_act && !fault_response_en_i && !fault_trip_o) |=> (!fault_trip_o && fault_seen_o);
	endproperty
	a_fault_gated: assert property (p_fault_gated) else $error("disabled fault response acted");

	property p_presence_decode;
		@(posedge clock_i) disable iff (rst_i)
		card_power_class_o == hpsi_decode_presence($past(sw_stable[`HPSI_SW_PRES_A]),
			$past(sw_stable[`HPSI_SW_PRES_B]));
	endproperty
	a_presence_decode: assert property (p_presence_decode) else $error("wrong power class");

	property p_latch_sense;
		@(posedge clock_i) disable iff (rst_i)
		latch_closed_o == !$past(sw_stable[`HPSI_SW_LATCH]);
	endproperty
	a_latch_sense: assert property (p_latch_sense) else $error("latch sense inverted");

	property p_attention_pulse;
		@(posedge clock_i) disable iff (rst_i)
		$fell(sw_stable[`HPSI_SW_BUTTON]) |=> attention_request_o ##1 !attention_request_o;
	endproperty
	a_attention_pulse: assert property (p_attention_pulse) else $error("attention request missing");

	property p_fast_sample;
		@(posedge clock_i) disable iff (rst_i)
		$rose(seg_card_fast_capable_i) ##1 seg_card_fast_capable_i[*2] |=> card_fast_capable_o;
	endproperty
	a_fast_sample: assert property (p_fast_sample) else $error("speed capability not sampled");

	property p_power_enable;
		@(posedge clock_i) disable iff (rst_i)
		// the first edge after reset still shows the reset value, not the command
		!$past(rst_i) |-> ($past(direct_mode && power_cmd_i) == seg_slot_power_enable_o);
	endproperty
	a_power_enable: assert property (p_power_enable) else $error("power enable mismatch");

	property p_indicators;
		@(posedge clock_i) disable iff (rst_i)
		(!direct_mode) |=> (seg_power_indicator_n_o && seg_attention_indicator_n_o && !seg_slot_power_enable_o
			&& !seg_slot_reset_n_o);
	endproperty
	a_indicators: assert property (p_indicators) else $error("slot driven outside direct mode");

	property p_reset_state;
		@(posedge clock_i)
		rst_i |-> (!seg_slot_reset_n_o && !seg_slot_power_enable_o && seg_power_indicator_n_o
			&& seg_attention_indicator_n_o);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad slot state in reset");

	c_fault_trip: cover property (@(posedge clock_i) disable iff (rst_i) $rose(fault_trip_o));
	c_button: cover property (@(posedge clock_i) disable iff (rst_i) attention_request_o);
	c_run: cover property (@(posedge clock_i) disable iff (rst_i) seg_slot_reset_n_o && seg_slot_power_enable_o);

endmodule // hpsi_slot_if
`default_nettype wire

// File: verification/hpsi_slot_model.sv
// partner model: one expansion slot with its power controller, latch sensor and button
`timescale 1ns/100ps
`default_nettype none

module hpsi_slot_model (
	input  wire logic       power_en_i,           // slot power from the device
	input  wire logic [1:0] card_code_i,          // card presence straps, {a,b}
	input  wire logic       latch_fitted_i,       // platform has a latch sensor
	input  wire logic       latch_open_i,         // latch state when fitted
	input  wire logic       button_fitted_i,      // platform has a button
	input  wire logic       press_i,              // operator holds the button
	input  wire logic       fault_i,              // power controller trips
	input  wire logic       card_fast_i,          // card leaves its speed pin high
	output logic            power_fault_n_o,
	output logic            presence_a_n_o,
	output logic            presence_b_n_o,
	output logic            latch_sensor_n_o,
	output logic            attention_button_n_o,
	output logic            card_fast_o
);
	// presence straps come straight from the card edge
	assign presence_a_n_o = card_code_i[1];
	assign presence_b_n_o = card_code_i[0];
	// no sensor: strap low so the latch always reads closed
	assign latch_sensor_n_o = latch_fitted_i ? latch_open_i : 1'h0;
	// no button: strap high so no request is ever seen
	assign attention_button_n_o = button_fitted_i ? ~press_i : 1'h1;
	// fault flag of the power controller, active low
	assign power_fault_n_o = ~fault_i;
	// speed pin pulled up to the switched rail, so it reads low while unpowered
	assign card_fast_o = power_en_i & card_fast_i;
endmodule // hpsi_slot_model

`default_nettype wire

// File: verification/test_hpsi_slot_if.sv
// self-checking bench for the hot-plug slot interface
`timescale 1ns/100ps
`default_nettype none
`include "hpsi_defines.svh"

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end

module test_hpsi_slot_if
	import hpsi_pkg::*;
;
	localparam int unsigned DEB = 8;        // short filter for simulation
	localparam int          SETTLE = DEB + 12; // sync, filter and status margin
	logic clock_i, rst_i, pf_n, pa_n, pb_n, lt_n, bt_n, fs;
	logic [3:0] slot_count_i;
	logic fault_response_en_i, fault_clear_i, power_cmd_i, bus_connect_cmd_i, slot_run_cmd_i;
	logic power_indicator_on_i, attention_indicator_on_i;
	logic seg_slot_power_enable_o, seg_slot_reset_n_o, seg_power_indicator_n_o, seg_attention_indicator_n_o;
	logic direct_mode_o, bus_connect_o, fault_trip_o, fault_seen_o, latch_closed_o;
	logic attention_request_o, card_fast_capable_o;
	hpsi_pwr_class_t card_power_class_o;
	logic [1:0] card_code;                  // far-side stimulus
	logic latch_fitted, latch_open, button_fitted, press, fault, card_fast;
	int n_mismatch = 0;
	int tests_run = 0;
	int n_pulse = 0;                        // attention pulses seen

	hpsi_slot_if #(.DEBOUNCE_CYCLES(DEB)) u_hpsi_slot_if (.clock_i(clock_i), .rst_i(rst_i),
		.seg_power_fault_n_i(pf_n), .seg_presence_a_n_i(pa_n), .seg_presence_b_n_i(pb_n),
		.seg_latch_sensor_n_i(lt_n), .seg_attention_button_n_i(bt_n), .seg_card_fast_capable_i(fs),
		.seg_slot_power_enable_o(seg_slot_power_enable_o), .seg_slot_reset_n_o(seg_slot_reset_n_o),
		.seg_power_indicator_n_o(seg_power_indicator_n_o),
		.seg_attention_indicator_n_o(seg_attention_indicator_n_o), .slot_count_i(slot_count_i),
		.fault_response_en_i(fault_response_en_i), .fault_clear_i(fault_clear_i),
		.power_cmd_i(power_cmd_i), .bus_connect_cmd_i(bus_connect_cmd_i), .slot_run_cmd_i(slot_run_cmd_i),
		.power_indicator_on_i(power_indicator_on_i), .attention_indicator_on_i(attention_indicator_on_i),
		.direct_mode_o(direct_mode_o), .bus_connect_o(bus_connect_o), .fault_trip_o(fault_trip_o),
		.fault_seen_o(fault_seen_o), .card_power_class_o(card_power_class_o),
		.latch_closed_o(latch_closed_o), .attention_request_o(attention_request_o),
		.card_fast_capable_o(card_fast_capable_o));

	hpsi_slot_model u_hpsi_slot_model (.power_en_i(seg_slot_power_enable_o), .card_code_i(card_code),
		.latch_fitted_i(latch_fitted), .latch_open_i(latch_open), .button_fitted_i(button_fitted),
		.press_i(press), .fault_i(fault), .card_fast_i(card_fast), .power_fault_n_o(pf_n),
		.presence_a_n_o(pa_n), .presence_b_n_o(pb_n), .latch_sensor_n_o(lt_n),
		.attention_button_n_o(bt_n), .card_fast_o(fs));

	// free-running clock, 50 ns period
	initial begin
		clock_i = 1'h0;
		forever #25 clock_i = ~clock_i;
	end

	// count attention pulses so a doubled or missing pulse shows
	always @(posedge clock_i) begin
		if (attention_request_o === 1'h1) n_pulse++;
	end

	task automatic step(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// commands are already asked for, yet reset must keep the slot off
	task automatic t_reset_state;
		`CHK("slot_reset_n", 1'h0, seg_slot_reset_n_o)
		`CHK("power_enable", 1'h0, seg_slot_power_enable_o)
		`CHK("indicators_n", 2'h3, {seg_power_indicator_n_o, seg_attention_indicator_n_o})
	endtask

	// wrong slot count holds everything off; count one releases the commands
	task automatic t_direct_mode;
		slot_count_i = 4'h2;
		step(2);
		`CHK("direct_mode", 1'h0, direct_mode_o)
		`CHK("power_enable", 1'h0, seg_slot_power_enable_o)
		slot_count_i = 4'h1;
		step(2);
		`CHK("direct_mode", 1'h1, direct_mode_o)
		`CHK("power_enable", 1'h1, seg_slot_power_enable_o)
		`CHK("slot_reset_n", 1'h1, seg_slot_reset_n_o)
		`CHK("indicators_n", 2'h0, {seg_power_indicator_n_o, seg_attention_indicator_n_o})
		power_indicator_on_i = 1'h0;
		slot_run_cmd_i = 1'h0;
		step(1);
		`CHK("indicators_n", 2'h2, {seg_power_indicator_n_o, seg_attention_indicator_n_o})
		`CHK("slot_reset_n", 1'h0, seg_slot_reset_n_o)
		power_indicator_on_i = 1'h1;
		slot_run_cmd_i = 1'h1;
		step(1);
	endtask

	// fault with the response on isolates in three edges; off, it is only noted
	task automatic t_fault(input logic en);
		fault_response_en_i = en;
		fault = 1'h1;
		step(2);
		`CHK("slot_reset_n", 1'h1, seg_slot_reset_n_o)
		step(1);
		`CHK("slot_reset_n", ~en, seg_slot_reset_n_o)
		`CHK("bus_connect", ~en, bus_connect_o)
		`CHK("fault_trip", en, fault_trip_o)
		`CHK("fault_seen", 1'h1, fault_seen_o)
		`CHK("power_enable", 1'h1, seg_slot_power_enable_o)
		fault = 1'h0;
		step(3);
		fault_clear_i = 1'h1;
		step(1);
		fault_clear_i = 1'h0;
		step(1);
		`CHK("fault_trip", 1'h0, fault_trip_o)
		`CHK("fault_seen", 1'h0, fault_seen_o)
		`CHK("slot_reset_n", 1'h1, seg_slot_reset_n_o)
	endtask

	// every presence strap pair, ending with a card in the slot
	task automatic t_presence;
		hpsi_pwr_class_t exp_cls [4];
		exp_cls = '{HPSI_BOARD_7W5, HPSI_BOARD_25W, HPSI_BOARD_15W, HPSI_NO_BOARD};
		for (int i = 3; i >= 0; i--) begin
			card_code = 2'(i);
			step(SETTLE);
			`CHK("power_class", exp_cls[i], card_power_class_o)
		end
	endtask

	// latch open, closed, and a platform without a sensor
	task automatic t_latch;
		latch_open = 1'h1;
		step(SETTLE);
		`CHK("latch_closed", 1'h0, latch_closed_o)
		latch_open = 1'h0;
		step(SETTLE);
		`CHK("latch_closed", 1'h1, latch_closed_o)
		latch_fitted = 1'h0;
		latch_open = 1'h1;
		step(SETTLE);
		`CHK("latch_closed", 1'h1, latch_closed_o)
	endtask

	// a short bounce is dropped, a held press gives one pulse after the full interval
	task automatic t_button;
		press = 1'h1;
		step(3);
		press = 1'h0;
		step(SETTLE);
		`CHK("glitch_pulses", 0, n_pulse)
		press = 1'h1;
		step(DEB);
		`CHK("early_pulses", 0, n_pulse)
		step(12);
		`CHK("press_pulses", 1, n_pulse)
		press = 1'h0;
		step(SETTLE);
		`CHK("release_pulses", 1, n_pulse)
		button_fitted = 1'h0;
		press = 1'h1;
		step(SETTLE);
		`CHK("unfitted_pulses", 1, n_pulse)
	endtask

	// speed capability follows the pin with the slot powered
	task automatic t_speed;
		card_fast = 1'h1;
		step(4);
		`CHK("card_fast", 1'h1, card_fast_capable_o)
		card_fast = 1'h0;
		step(4);
		`CHK("card_fast", 1'h0, card_fast_capable_o)
	endtask

	// main sequence
	initial begin
		rst_i = 1'h1;
		slot_count_i = 4'h1;
		{fault_response_en_i, fault_clear_i} = 2'h0;
		{power_cmd_i, bus_connect_cmd_i, slot_run_cmd_i} = 3'h7;
		{power_indicator_on_i, attention_indicator_on_i} = 2'h3;
		card_code = 2'h3;
		{latch_fitted, latch_open, button_fitted, press, fault, card_fast} = 6'h28;
		step(11);
		t_reset_state();
		step(1);
		rst_i = 1'h0;
		t_direct_mode();
		t_fault(1'h1);
		t_fault(1'h0);
		t_presence();
		t_latch();
		t_button();
		t_speed();
		// reset in mid-run, with the slot powered and running
		rst_i = 1'h1;
		step(1);
		t_reset_state();
		rst_i = 1'h0;
		step(2);
		`CHK("power_enable", 1'h1, seg_slot_power_enable_o)
		`CHK("slot_reset_n", 1'h1, seg_slot_reset_n_o)
		tally_and_finish();
	end

	// watchdog: the run needs a few hundred cycles
	initial begin
		#(50 * 2000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule // test_hpsi_slot_if

`default_nettype wire
